// ---- common/lcell_pkg.sv ----
package lcell_pkg;

  // Register map, byte addresses on the APB
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_LUT_MASK = 12'h000;
  localparam logic [11:0] OFF_CELL_CTRL = 12'h004;
  localparam logic [11:0] OFF_CELL_STAT = 12'h008;

  localparam logic [15:0] LUT_MASK_RST = 16'h0000;
  localparam logic [31:0] CELL_CTRL_RST = 32'h0000_0000;
  // Reserved control bits are dropped on write and read back as zero
  localparam logic [31:0] CELL_CTRL_WMASK = 32'h01ff_ffff;

  // Status word bit positions
  localparam int unsigned ST_Q = 0;
  localparam int unsigned ST_COMB = 1;
  localparam int unsigned ST_COUT = 2;
  localparam int unsigned ST_CASC = 3;

  // Control source codes: 0..3 global lines, 4..5 general pins, 6 the cell's own logic, 7 none
  localparam logic [2:0] SRC_PIN_BASE = 3'h4;
  localparam logic [2:0] SRC_INTERNAL = 3'h6;
  localparam logic [2:0] SRC_NONE = 3'h7;
  localparam int unsigned N_GLOBAL = 4;
  localparam int unsigned N_PIN = 2;

  // Data input used as the second operand (K or R) of the storage element
  localparam int unsigned SECOND_IDX = 2;

  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} lcell_ff_t;
  typedef enum logic [1:0] {SEL_LUT, SEL_REG, SEL_CASC, SEL_ZERO} lcell_osel_t;
  typedef enum logic [1:0] {RIN_LUT, RIN_FOURTH, RIN_PICK, RIN_CARRY} lcell_rin_t;

  typedef struct packed {
    logic [6:0] rsvd;
    logic [2:0] pre_src;
    logic [2:0] clr_src;
    logic [2:0] clk_src;
    logic chain_init;
    logic chain_start;
    logic casc_en;
    logic [1:0] pick_idx;
    lcell_rin_t reg_src;
    logic cin_sel;
    lcell_osel_t long_sel;
    lcell_osel_t local_sel;
    logic bypass;
    lcell_ff_t ff_type;
    logic arith;
  } lcell_ctrl_t;

  typedef struct packed {
    logic [3:0] data;
    logic carry_in;
    logic cascade_in;
    logic clk_ena;
  } lcell_route_in_t;

  typedef struct packed {
    logic local_out;
    logic long_out;
    logic carry_out;
    logic cascade_out;
  } lcell_route_out_t;

endpackage

// ---- core/lcell_lut.sv ----
`timescale 1ns/100ps
module lcell_lut
  import lcell_pkg::*;
(
  input wire logic [15:0] i_mask,
  input wire logic i_arith,
  input wire logic i_cin_sel,
  input wire logic [3:0] i_data,
  input wire logic i_cin,
  output logic o_y,
  output logic o_cout
);

  wire logic third_in = i_cin_sel ? i_cin : i_data[2];
  wire logic [3:0] norm_idx = {i_data[3], third_in, i_data[1], i_data[0]};
  wire logic [2:0] arith_idx = {i_cin, i_data[1], i_data[0]};

  // Arithmetic mode splits the mask: low half forms the result, high half the carry
  assign o_y = i_arith ? i_mask[{1'b0, arith_idx}] : i_mask[norm_idx];
  // In normal mode the incoming carry runs straight on to the next cell
  assign o_cout = i_arith ? i_mask[{1'b1, arith_idx}] : i_cin;

endmodule // lcell_lut

// ---- core/lcell_ff.sv ----
`timescale 1ns/100ps
module lcell_ff
  import lcell_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire lcell_ff_t i_ff_type,
  input wire logic i_cap,
  input wire logic i_a,
  input wire logic i_b,
  input wire logic i_clr,
  input wire logic i_pre,
  output logic o_q
);

  logic next_q;
  wire logic clr_any = i_rst | i_clr;
  // Preset is gated by clear, so releasing clear under a held preset is itself an edge
  wire logic pre_eff = i_pre & ~clr_any;

  always_comb begin
    next_q = o_q;
    case (i_ff_type)
      FF_D: next_q = i_a;
      FF_T: next_q = o_q ^ i_a;
      FF_JK: begin
        case ({i_a, i_b})
          2'b01: next_q = 1'b0;
          2'b10: next_q = 1'b1;
          2'b11: next_q = ~o_q;
          default: next_q = o_q;
        endcase
      end
      default: begin
        // Set and reset together is held, not guessed
        if (i_a && !i_b) begin
          next_q = 1'b1;
        end else if (i_b && !i_a) begin
          next_q = 1'b0;
        end
      end
    endcase
  end

  // Clear beats preset; enable gates only the clocked capture
  always_ff @(posedge i_mclk or posedge clr_any or posedge pre_eff) begin
    if (clr_any) begin
      o_q <= 1'b0;
    end else if (pre_eff) begin
      o_q <= 1'b1;
    end else if (i_cap) begin
      o_q <= next_q;
    end
  end

  clr_wins_a: assert property (@(posedge i_mclk) disable iff (i_rst) i_clr |-> !o_q)
    else $error("clear did not force the register low");
  pre_sets_a: assert property (@(posedge i_mclk) disable iff (i_rst) (i_pre && !i_clr) |-> o_q)
    else $error("preset did not force the register high");

endmodule // lcell_ff

// ---- core/lcell_top.sv ----
// How it works
// - Storage element works as D, T, JK or SR
// - Clock, clear, preset picked from globals, pins, logic
// - Combinational use bypasses the register entirely
// - Two outputs, each with its own source choice
// - Carry-in feeds table and forward carry logic
// - Chains link every cell and neighbouring clusters
// - Long carry chains hop to alternate clusters
// - Chain restarts around the embedded memory block
// - N-bit adder uses one extra carry cell
// - Adder sum is combinational or accumulated
// - Normal mode: four-input table, carry or third input
// - Table output combined with cascade-in drives cascade-out
// - Register or table may drive both outputs
// - Fourth data input may feed the register directly
// - One table input may also feed the register
// - Packed register keeps enable, clear, preset, outputs
// - Arithmetic mode: first three-input table gives result
// - Second three-input table makes the carry-out
// - Cascade chain still usable in arithmetic mode
`timescale 1ns/100ps
module lcell_top
  import lcell_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire lcell_route_in_t i_route,
  input wire logic [N_GLOBAL-1:0] i_global,
  input wire logic [N_PIN-1:0] i_pin,
  output lcell_route_out_t o_route
);

  logic [15:0] lut_mask;
  lcell_ctrl_t ctrl;
  logic [N_GLOBAL+N_PIN-1:0] sync_meta;
  logic [N_GLOBAL+N_PIN-1:0] sync_lvl;
  logic clk_prev;
  logic q;
  logic lut_y;
  logic lut_cout;

  function automatic logic pick_src(input logic [2:0] sel, input logic [N_GLOBAL+N_PIN-1:0] lines,
                                    input logic own);
    logic r;
    r = 1'b0;
    if (sel == SRC_INTERNAL) begin
      r = own;
    end else if (sel != SRC_NONE) begin
      r = lines[sel];
    end
    return r;
  endfunction

  function automatic logic out_mux(input lcell_osel_t sel, input logic lut, input logic reg_q,
                                   input logic casc);
    logic r;
    r = 1'b0;
    case (sel)
      SEL_LUT: r = lut;
      SEL_REG: r = reg_q;
      SEL_CASC: r = casc;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // APB decode and handshake; zero wait states
  wire logic apb_access = i_psel & i_penable;
  wire logic apb_setup = i_psel & ~i_penable;
  wire logic hit_mask = (i_paddr == OFF_LUT_MASK);
  wire logic hit_ctrl = (i_paddr == OFF_CELL_CTRL);
  wire logic hit_stat = (i_paddr == OFF_CELL_STAT);
  wire logic hit_any = hit_mask | hit_ctrl | hit_stat;
  wire logic wr_mask = apb_access & i_pwrite & hit_mask;
  wire logic wr_ctrl = apb_access & i_pwrite & hit_ctrl;

  assign o_pready = apb_access;
  assign o_pslverr = apb_access & ~hit_any;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      lut_mask <= LUT_MASK_RST;
    end else if (wr_mask) begin
      lut_mask <= i_pwdata[15:0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ctrl <= lcell_ctrl_t'(CELL_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl <= lcell_ctrl_t'(i_pwdata & CELL_CTRL_WMASK);
    end
  end

  // Global lines and pins come from outside the clock domain
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sync_meta <= '0;
      sync_lvl <= '0;
    end else begin
      sync_meta <= {i_pin, i_global};
      sync_lvl <= sync_meta;
    end
  end

  // Chain start cuts the incoming carry, e.g. at a memory block or a cluster hop seam
  wire logic cin_eff = ctrl.chain_start ? ctrl.chain_init : i_route.carry_in;

  lcell_lut u_lut (
    .i_mask(lut_mask),
    .i_arith(ctrl.arith),
    .i_cin_sel(ctrl.cin_sel),
    .i_data(i_route.data),
    .i_cin(cin_eff),
    .o_y(lut_y),
    .o_cout(lut_cout)
  );

  // Cascade combine is an AND; works in both modes
  wire logic casc_y = ctrl.casc_en ? (lut_y & i_route.cascade_in) : lut_y;

  // Control lines: each chosen independently
  wire logic clk_lvl = pick_src(ctrl.clk_src, sync_lvl, casc_y);
  wire logic clr_lvl = pick_src(ctrl.clr_src, sync_lvl, casc_y);
  wire logic pre_lvl = pick_src(ctrl.pre_src, sync_lvl, casc_y);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= clk_lvl;
    end
  end

  // A rising edge of the chosen clock line, qualified by clock enable, captures
  wire logic cap = clk_lvl & ~clk_prev & i_route.clk_ena;

  // Register input: table result (accumulator), fourth input, any table input, or carry
  wire logic reg_a = (ctrl.reg_src == RIN_FOURTH) ? i_route.data[3] :
                     (ctrl.reg_src == RIN_PICK) ? i_route.data[ctrl.pick_idx] :
                     (ctrl.reg_src == RIN_CARRY) ? cin_eff :
                     casc_y;

  lcell_ff u_ff (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ff_type(ctrl.ff_type),
    .i_cap(cap),
    .i_a(reg_a),
    .i_b(i_route.data[SECOND_IDX]),
    .i_clr(clr_lvl),
    .i_pre(pre_lvl),
    .o_q(q)
  );

  // Each output follows its own select (table, register or cascade); the bypass bit forces both to the table result
  wire logic local_y = ctrl.bypass ? casc_y : out_mux(ctrl.local_sel, casc_y, q, casc_y);
  wire logic long_y = ctrl.bypass ? casc_y : out_mux(ctrl.long_sel, casc_y, q, casc_y);

  assign o_route.local_out = local_y;
  assign o_route.long_out = long_y;
  assign o_route.carry_out = lut_cout;
  assign o_route.cascade_out = casc_y;

  // Read data is latched in the setup cycle so it is a flop in the access cycle
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_mask) begin
      rd_word = {16'h0000, lut_mask};
    end else if (hit_ctrl) begin
      rd_word = 32'(ctrl);
    end else if (hit_stat) begin
      rd_word[ST_Q] = q;
      rd_word[ST_COMB] = lut_y;
      rd_word[ST_COUT] = lut_cout;
      rd_word[ST_CASC] = casc_y;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (apb_setup) begin
      o_prdata <= rd_word;
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  bypass_out_a: assert property (ctrl.bypass |-> (local_y == casc_y) && (long_y == casc_y))
    else $error("bypassed cell output differs from table result");

  dual_out_a: assert property ((!ctrl.bypass && ctrl.local_sel == SEL_REG &&
                                ctrl.long_sel == SEL_LUT) |-> (o_route.local_out == q) &&
                               (o_route.long_out == casc_y))
    else $error("outputs not driven from their own sources");

  carry_fwd_a: assert property ((ctrl.arith && !ctrl.chain_start) |->
                                o_route.carry_out == lut_mask[{1'b1, i_route.carry_in, i_route.data[1:0]}])
    else $error("carry out does not follow carry table");

  chain_cut_a: assert property ((!ctrl.arith && ctrl.chain_start) |->
                                o_route.carry_out == ctrl.chain_init)
    else $error("carry chain not restarted");

  sum_tbl_a: assert property ((ctrl.arith && !ctrl.casc_en && ctrl.local_sel == SEL_LUT) |->
                              o_route.local_out == lut_mask[{1'b0, cin_eff, i_route.data[1:0]}])
    else $error("arithmetic result does not follow sum table");

  casc_and_a: assert property (ctrl.casc_en |->
                               o_route.cascade_out == (lut_y & i_route.cascade_in))
    else $error("cascade out is not table and cascade in");

  pack_fourth_a: assert property (((cap && ctrl.ff_type == FF_D && ctrl.reg_src == RIN_FOURTH &&
                                    !clr_lvl && !pre_lvl) ##1 (!clr_lvl && !pre_lvl)) |->
                                  q == $past(i_route.data[3]))
    else $error("fourth input not captured");

  toggle_a: assert property (((cap && ctrl.ff_type == FF_T && reg_a && !clr_lvl && !pre_lvl)
                              ##1 (!clr_lvl && !pre_lvl)) |-> q != $past(q))
    else $error("T register did not toggle");

  hold_a: assert property (((!cap && !clr_lvl && !pre_lvl) ##1 (!clr_lvl && !pre_lvl)) |->
                           $stable(q))
    else $error("register changed without capture");

  ctrl_wr_a: assert property (wr_ctrl |=> 32'(ctrl) == ($past(i_pwdata) & CELL_CTRL_WMASK))
    else $error("control write not stored");

  carry_pass_a: assert property ((!ctrl.arith && !ctrl.chain_start) |->
                                 o_route.carry_out == i_route.carry_in)
    else $error("carry in not passed forward");

  norm_tbl_a: assert property ((!ctrl.arith && !ctrl.casc_en) |->
                               o_route.cascade_out == lut_mask[{i_route.data[3],
                               (ctrl.cin_sel ? cin_eff : i_route.data[2]), i_route.data[1:0]}])
    else $error("normal mode table result wrong");

  mask_wr_a: assert property (wr_mask |=> lut_mask == $past(i_pwdata[15:0]))
    else $error("table mask write not stored");

  rd_latch_a: assert property ((apb_setup && hit_mask) |=> o_prdata == {16'h0000, $past(lut_mask)})
    else $error("read data not taken in the setup cycle");

  arith_carry_c: cover property (ctrl.arith && o_route.carry_out && ctrl.casc_en);
  toggle_c: cover property (cap && ctrl.ff_type == FF_T ##1 q);
  packed_c: cover property (ctrl.reg_src == RIN_FOURTH && ctrl.local_sel == SEL_REG && cap);
  clr_c: cover property (clr_lvl && pre_lvl);
  accum_c: cover property (cap && ctrl.reg_src == RIN_LUT);

endmodule // lcell_top

// ---- verif/lcell_nbr.sv ----
`timescale 1ns/100ps
module lcell_nbr (
  input wire logic i_a,
  input wire logic i_b,
  input wire logic i_cin,
  input wire logic i_casc,
  output logic o_carry,
  output logic o_casc
);
  // Lower-order neighbour in arithmetic mode; only its chain outputs matter here
  assign o_carry = (i_a & i_b) | (i_cin & (i_a ^ i_b));
  assign o_casc = i_casc & (i_a | i_b);
endmodule // lcell_nbr

// ---- verif/fpga_logic_cell_carry_cascade_tb.sv ----
`timescale 1ns/100ps
module fpga_logic_cell_carry_cascade_tb;
  import lcell_pkg::*;
  logic i_mclk, i_rst, psel, penable, pwrite, pready, pslverr, err, q, y, ci;
  logic cena, na, nb, ncin, ncasc, ncarry, ncasc_o;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] d, glb;
  logic [1:0] pin;
  logic [15:0] mask;
  lcell_route_in_t route;
  lcell_route_out_t rout;
  lcell_ctrl_t c;
  int n_mismatch, compares;
  integer seed;

  assign route = {d, ncarry, ncasc_o, cena};
  lcell_top u_lcell_top (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_route(route), .i_global(glb), .i_pin(pin), .o_route(rout));
  lcell_nbr u_lcell_nbr (.i_a(na), .i_b(nb), .i_cin(ncin), .i_casc(ncasc), .o_carry(ncarry),
    .o_casc(ncasc_o));

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  function automatic logic maj(input logic a, input logic b, input logic k);
    return (a & b) | (k & (a ^ b));
  endfunction

  // SR with both inputs set holds its state
  function automatic logic ff_next(input lcell_ff_t t, input logic s, input logic a, input logic b);
    case (t)
      FF_D: return a;
      FF_T: return s ^ a;
      FF_JK: return (a & ~s) | (~b & s);
      default: return (a ^ b) ? a : s;
    endcase
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Entered just after a rising edge; request held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_mclk);
    penable <= 1'b1;
    @(posedge i_mclk);
    while (pready !== 1'b1) begin
      @(posedge i_mclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never re-raises psel in the same step
    @(posedge i_mclk);
  endtask

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
    chk("slverr", e, err);
  endtask

  initial begin
    // Sized for every scenario with a wide margin for slow answers
    repeat (20000) @(posedge i_mclk);
    n_mismatch++;
    stop_test();
  end

  initial begin
    seed = 32'hf16d9a45;
    n_mismatch = 0;
    compares = 0;
    i_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {d, glb, pin, na, nb, ncin, ncasc} = '0;
    cena = 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    rchk("mask rst", OFF_LUT_MASK, {16'h0, LUT_MASK_RST}, 1'b0);
    rchk("ctrl rst", OFF_CELL_CTRL, CELL_CTRL_RST, 1'b0);
    rchk("unmapped", 12'h00c, 32'h0, 1'b1);
    apb(1'b1, OFF_CELL_CTRL, 32'hffff_ffff);
    rchk("ctrl rsvd", OFF_CELL_CTRL, CELL_CTRL_WMASK, 1'b0);
    $display("test registers done");
    for (int i = 0; i < 24; i++) begin
      mask = 16'($random(seed));
      c = lcell_ctrl_t'({7'h0, {3{SRC_NONE}}, 16'h0});
      c.bypass = 1'b1;
      c.cin_sel = i[1];
      c.casc_en = i[0];
      c.long_sel = i[0] ? SEL_CASC : SEL_LUT;
      c.chain_start = i[2];
      c.chain_init = i[3];
      apb(1'b1, OFF_LUT_MASK, {16'h0, mask});
      apb(1'b1, OFF_CELL_CTRL, c);
      d <= 4'($random(seed));
      {na, nb, ncin, ncasc} <= 4'($random(seed));
      @(negedge i_mclk);
      ci = c.chain_start ? c.chain_init : ncarry;
      y = mask[{d[3], c.cin_sel ? ci : d[2], d[1:0]}];
      chk("carry pass", ci, rout.carry_out);
      if (c.casc_en) begin
        chk("casc out", y & ncasc_o, rout.cascade_out);
        chk("casc long", y & ncasc_o, rout.long_out);
      end else begin
        chk("lut local", y, rout.local_out);
        chk("lut long", y, rout.long_out);
        chk("casc pass", y, rout.cascade_out);
      end
      @(posedge i_mclk);
    end
    $display("test normal done");
    apb(1'b1, OFF_LUT_MASK, 32'h0000_e896);
    for (int i = 0; i < 32; i++) begin
      c = lcell_ctrl_t'({7'h0, {3{SRC_NONE}}, 16'h0});
      c.arith = 1'b1;
      c.bypass = 1'b1;
      c.casc_en = i[0];
      c.long_sel = SEL_CASC;
      c.chain_start = i[1];
      c.chain_init = i[2];
      apb(1'b1, OFF_CELL_CTRL, c);
      d <= 4'($random(seed));
      {na, nb, ncin, ncasc} <= 4'($random(seed));
      @(negedge i_mclk);
      ci = c.chain_start ? c.chain_init : ncarry;
      y = d[0] ^ d[1] ^ ci;
      chk("arith carry", maj(d[0], d[1], ci), rout.carry_out);
      if (c.casc_en) begin
        chk("arith casc", y & ncasc_o, rout.cascade_out);
      end else begin
        chk("arith sum", y, rout.local_out);
      end
      @(posedge i_mclk);
    end
    $display("test arith done");
    mask = 16'h6ac5;
    apb(1'b1, OFF_LUT_MASK, {16'h0, mask});
    q = 1'b0;
    for (int i = 0; i < 24; i++) begin
      c = lcell_ctrl_t'('0);
      c.ff_type = lcell_ff_t'(i / 6);
      c.local_sel = SEL_REG;
      c.reg_src = lcell_rin_t'(i % 4);
      c.pick_idx = 2'h1;
      c.clr_src = SRC_PIN_BASE;
      c.pre_src = 3'h1;
      apb(1'b1, OFF_CELL_CTRL, c);
      d <= 4'($random(seed));
      cena <= (i % 5) != 3;
      @(posedge i_mclk);
      glb[0] <= 1'b1;
      repeat (5) @(posedge i_mclk);
      glb[0] <= 1'b0;
      repeat (3) @(posedge i_mclk);
      @(negedge i_mclk);
      // Register input by source: table result, fourth input, picked input, carry-in
      ci = (i % 4 == 0) ? mask[d] : (i % 4 == 1) ? d[3] : (i % 4 == 2) ? d[1] : ncarry;
      if (cena) q = ff_next(c.ff_type, q, ci, d[SECOND_IDX]);
      chk("reg local", q, rout.local_out);
      chk("lut long", mask[d], rout.long_out);
      @(posedge i_mclk);
    end
    pin[0] <= 1'b1;
    glb[1] <= 1'b1;
    repeat (4) @(posedge i_mclk);
    glb[0] <= 1'b1;
    repeat (4) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("clear wins", 1'b0, rout.local_out);
    @(posedge i_mclk);
    pin[0] <= 1'b0;
    repeat (4) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("preset", 1'b1, rout.local_out);
    @(posedge i_mclk);
    glb[1] <= 1'b0;
    repeat (4) @(posedge i_mclk);
    apb(1'b0, OFF_CELL_STAT, 32'h0);
    chk("stat q", 1'b1, rd[ST_Q]);
    chk("stat word", {28'h0, mask[d], ncarry, mask[d], 1'b1}, rd);
    $display("test register done");
    stop_test();
  end
endmodule // fpga_logic_cell_carry_cascade_tb
